/* File: verilog/pbmc_top.sv */
// Functional notes
// - soft reset bit reads one, then self-clears
// - soft reset re-samples strap inputs
// - loopback routes transmit data into receive
// - loopback may withhold receive data 500us
// - manual speed bit: one 100, zero 10
// - autoneg enable resets from strap input
// - autoneg on ignores speed and duplex bits
// - autoneg off uses speed and duplex bits
// - power down stops all but registers
// - isolate cuts mii, management keeps working
// - restart bit re-initiates autoneg when enabled
// - restart write ignored while autoneg disabled
// - restart bit reads one until initiated
// - writing zero to restart never disturbs running autoneg while enable stays one
// - duplex bit selects duplex when autoneg off
// - duplex one full, zero half
`timescale 1ns/1ps
module pbmc_top #(
  parameter int LOOP_DEAD_CYCLES = pbmc_pkg::LOOP_DEAD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial management pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe_n,
  // strap pins
  input wire pbmc_pkg::pbmc_strap_s strapPins,
  // auto-negotiation engine
  input wire logic anStarted,
  input wire logic anSpeed100,
  input wire logic anFullDuplex,
  output logic anEnabled,
  output logic anRestart,
  // operating mode to the phy core
  output logic softResetBusy,
  output logic opSpeed100,
  output logic opFullDuplex,
  output logic powerDown,
  output logic isolate,
  // mac side mii
  input wire pbmc_pkg::pbmc_mii_s macTx,
  output pbmc_pkg::pbmc_mii_s macRx,
  output logic macRxOe_n,
  // line side
  input wire pbmc_pkg::pbmc_mii_s lineRx,
  output pbmc_pkg::pbmc_mii_s lineTx
);
  import pbmc_pkg::*;

  typedef struct packed {
    logic [2:0] mdcSync;
    logic [1:0] mdioSync;
    pbmc_strap_s strapSync1;
    pbmc_strap_s strapSync2;
    logic [1:0] strapWait;
    logic [4:0] phyAddr;
    pbmc_ctl_s ctl;
    logic [CNT_W-1:0] rstCnt;
    logic restartPend;
    logic opSpeed100;
    logic opFullDuplex;
    pbmc_mstate_e mst;
    logic [4:0] bitCnt;
    logic [1:0] op;
    logic [4:0] phyAd;
    logic [4:0] regAd;
    logic [DATA_W-1:0] shift;
    logic mdioOut;
    logic mdioOe_n;
  } pbmc_top_s;

  pbmc_top_s s_reg;
  pbmc_top_s s_next;
  logic mdcRise;
  logic mdioBit;
  logic frameHit;
  logic writeHit;
  logic [DATA_W-1:0] wData;
  logic [DATA_W-1:0] readValue;
  logic resetDone;

  assign mdcRise = s_reg.mdcSync[1] && !s_reg.mdcSync[2];
  assign mdioBit = s_reg.mdioSync[1];
  assign frameHit = s_reg.phyAd == s_reg.phyAddr && s_reg.regAd == REG_BASIC_MODE_CONTROL;
  assign wData = {s_reg.shift[DATA_W-2:0], mdioBit};
  assign writeHit = mdcRise && s_reg.mst == MS_WDATA && s_reg.bitCnt == DATA_BITS - 5'h01
    && s_reg.op == OP_WRITE && frameHit;
  assign resetDone = s_reg.rstCnt == CNT_W'(1);

  // busy and restart show live state, not stored write data
  always_comb begin
    readValue = '0;
    readValue[BIT_SOFT_RESET] = s_reg.rstCnt != '0;
    readValue[BIT_LOOPBACK] = s_reg.ctl.loopback;
    readValue[BIT_SPEED100] = s_reg.ctl.speed100;
    readValue[BIT_AN_ENABLE] = s_reg.ctl.anEnable;
    readValue[BIT_POWER_DOWN] = s_reg.ctl.powerDown;
    readValue[BIT_ISOLATE] = s_reg.ctl.isolate;
    readValue[BIT_AN_RESTART] = s_reg.restartPend;
    readValue[BIT_FULL_DUPLEX] = s_reg.ctl.fullDuplex;
    readValue[7:0] = LOW_BYTE_READ;
  end

  always_comb begin
    s_next = s_reg;
    s_next.mdcSync = {s_reg.mdcSync[1:0], mdc};
    s_next.mdioSync = {s_reg.mdioSync[0], mdioIn};
    s_next.strapSync1 = strapPins;
    s_next.strapSync2 = s_reg.strapSync1;

    // power-on strap capture once the synchroniser holds pin values
    if (s_reg.strapWait != '0) begin
      s_next.strapWait = s_reg.strapWait - 2'h1;
      if (s_reg.strapWait == 2'h1) begin
        s_next.phyAddr = s_reg.strapSync2.phyAddr;
        s_next.ctl.anEnable = s_reg.strapSync2.anEnable;
        s_next.ctl.speed100 = s_reg.strapSync2.speed100;
        s_next.ctl.fullDuplex = s_reg.strapSync2.fullDuplex;
      end
    end

    // management frame engine, one step per mdc rising edge
    if (mdcRise) begin
      s_next.bitCnt = s_reg.bitCnt + 5'h01;
      case (s_reg.mst)
        MS_IDLE: begin
          if (!mdioBit) begin
            s_next.mst = MS_START;
          end
        end
        MS_START: begin
          s_next.bitCnt = '0;
          s_next.mst = mdioBit ? MS_OP : MS_IDLE;
        end
        MS_OP: begin
          s_next.op = {s_reg.op[0], mdioBit};
          if (s_reg.bitCnt == OP_BITS - 5'h01) begin
            s_next.bitCnt = '0;
            s_next.mst = MS_PHYAD;
          end
        end
        MS_PHYAD: begin
          s_next.phyAd = {s_reg.phyAd[3:0], mdioBit};
          if (s_reg.bitCnt == ADDR_BITS - 5'h01) begin
            s_next.bitCnt = '0;
            s_next.mst = MS_REGAD;
          end
        end
        MS_REGAD: begin
          s_next.regAd = {s_reg.regAd[3:0], mdioBit};
          s_next.bitCnt = '0;
          if (s_reg.bitCnt == ADDR_BITS - 5'h01) begin
            s_next.mst = MS_TA;
          end else begin
            s_next.bitCnt = s_reg.bitCnt + 5'h01;
          end
        end
        MS_TA: begin
          // serial management keeps answering even while isolated
          if (s_reg.op == OP_READ) begin
            s_next.bitCnt = '0;
            if (s_reg.phyAd == s_reg.phyAddr) begin
              s_next.mdioOut = 1'b0;
              s_next.mdioOe_n = 1'b0;
              s_next.shift = (s_reg.regAd == REG_BASIC_MODE_CONTROL) ? readValue : '0;
              s_next.mst = MS_RDATA;
            end else begin
              s_next.mst = MS_IDLE;
            end
          end else if (s_reg.op == OP_WRITE && s_reg.bitCnt == TA_BITS - 5'h01) begin
            s_next.bitCnt = '0;
            s_next.mst = MS_WDATA;
          end else if (s_reg.op != OP_WRITE) begin
            s_next.mst = MS_IDLE;
          end
        end
        MS_WDATA: begin
          s_next.shift = wData;
          if (s_reg.bitCnt == DATA_BITS - 5'h01) begin
            s_next.mst = MS_IDLE;
          end
        end
        MS_RDATA: begin
          if (s_reg.bitCnt == DATA_BITS) begin
            s_next.mdioOe_n = 1'b1;
            s_next.mst = MS_IDLE;
          end else begin
            s_next.mdioOut = s_reg.shift[DATA_W-1];
            s_next.shift = {s_reg.shift[DATA_W-2:0], 1'b0};
          end
        end
        default: begin
          s_next.mst = MS_IDLE;
        end
      endcase
    end

    // initiation by the engine clears, a new request set below wins
    if (anStarted || !s_reg.ctl.anEnable) begin
      s_next.restartPend = 1'b0;
    end

    // writes during a soft reset are dropped; the core is being re-strapped
    if (writeHit && s_reg.rstCnt == '0) begin
      s_next.ctl.loopback = wData[BIT_LOOPBACK];
      s_next.ctl.speed100 = wData[BIT_SPEED100];
      s_next.ctl.anEnable = wData[BIT_AN_ENABLE];
      s_next.ctl.powerDown = wData[BIT_POWER_DOWN];
      s_next.ctl.isolate = wData[BIT_ISOLATE];
      s_next.ctl.fullDuplex = wData[BIT_FULL_DUPLEX];
      if (wData[BIT_SOFT_RESET]) begin
        s_next.rstCnt = SOFT_RESET_CYCLES;
      end
      // a zero leaves a pending or running restart alone while enable is written one
      if (wData[BIT_AN_RESTART] && wData[BIT_AN_ENABLE]) begin
        s_next.restartPend = 1'b1;
      end else if (!wData[BIT_AN_ENABLE]) begin
        s_next.restartPend = 1'b0;
      end
    end else if (s_reg.rstCnt != '0) begin
      s_next.rstCnt = s_reg.rstCnt - CNT_W'(1);
      if (resetDone) begin
        s_next.phyAddr = s_reg.strapSync2.phyAddr;
        s_next.ctl.anEnable = s_reg.strapSync2.anEnable;
        s_next.ctl.speed100 = s_reg.strapSync2.speed100;
        s_next.ctl.fullDuplex = s_reg.strapSync2.fullDuplex;
        s_next.ctl.loopback = RST_LOOPBACK;
        s_next.ctl.powerDown = RST_POWER_DOWN;
        s_next.ctl.isolate = RST_ISOLATE;
        s_next.restartPend = RST_AN_RESTART;
      end
    end

    // resolved mode: manual bits only count with autoneg off
    if (s_reg.ctl.anEnable) begin
      s_next.opSpeed100 = anSpeed100;
      s_next.opFullDuplex = anFullDuplex;
    end else begin
      s_next.opSpeed100 = s_reg.ctl.speed100;
      s_next.opFullDuplex = s_reg.ctl.fullDuplex;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.mdcSync <= 3'h7;
      s_reg.mdioSync <= 2'h3;
      s_reg.strapWait <= STRAP_WAIT_CYCLES;
      s_reg.mst <= MS_IDLE;
      s_reg.mdioOut <= 1'b1;
      s_reg.mdioOe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mdioOut = s_reg.mdioOut;
  assign mdioOe_n = s_reg.mdioOe_n;
  assign anEnabled = s_reg.ctl.anEnable;
  assign anRestart = s_reg.restartPend;
  assign softResetBusy = s_reg.rstCnt != '0;
  assign opSpeed100 = s_reg.opSpeed100;
  assign opFullDuplex = s_reg.opFullDuplex;
  assign powerDown = s_reg.ctl.powerDown;
  assign isolate = s_reg.ctl.isolate;

  pbmc_mii_path #(
    .DEAD_CYCLES(LOOP_DEAD_CYCLES)
  ) u_path (
    .clk(clk),
    .rst_n(rst_n),
    .loopback(s_reg.ctl.loopback),
    .isolate(s_reg.ctl.isolate),
    .powerDown(s_reg.ctl.powerDown),
    .macTx(macTx),
    .macRx(macRx),
    .macRxOe_n(macRxOe_n),
    .lineRx(lineRx),
    .lineTx(lineTx)
  );

  property p_reset_start;
    @(posedge clk) disable iff (!rst_n)
    writeHit && wData[BIT_SOFT_RESET] && !softResetBusy |=> softResetBusy [*8];
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("soft reset bit not held");

  property p_restrap;
    @(posedge clk) disable iff (!rst_n)
    $fell(softResetBusy) |-> anEnabled == $past(s_reg.strapSync2.anEnable)
      && s_reg.phyAddr == $past(s_reg.strapSync2.phyAddr);
  endproperty
  a_restrap: assert property (p_restrap) else $error("straps not re-applied");

  property p_reset_defaults;
    @(posedge clk) disable iff (!rst_n)
    $fell(softResetBusy) |-> !s_reg.ctl.loopback && !powerDown && !isolate;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("controls not defaulted");

  property p_manual_mode;
    @(posedge clk) disable iff (!rst_n)
    !anEnabled |=> opSpeed100 == $past(s_reg.ctl.speed100) && opFullDuplex == $past(s_reg.ctl.fullDuplex);
  endproperty
  a_manual_mode: assert property (p_manual_mode) else $error("manual mode bits not applied");

  property p_auto_mode;
    @(posedge clk) disable iff (!rst_n)
    anEnabled |=> opSpeed100 == $past(anSpeed100) && opFullDuplex == $past(anFullDuplex);
  endproperty
  a_auto_mode: assert property (p_auto_mode) else $error("manual bits leak into autoneg mode");

  property p_restart_set;
    @(posedge clk) disable iff (!rst_n)
    writeHit && !softResetBusy && wData[BIT_AN_RESTART] && wData[BIT_AN_ENABLE] |=> anRestart;
  endproperty
  a_restart_set: assert property (p_restart_set) else $error("restart not requested");

  property p_restart_ignored;
    @(posedge clk) disable iff (!rst_n)
    writeHit && !softResetBusy && !wData[BIT_AN_ENABLE] |=> !anRestart;
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("restart taken with autoneg off");

  property p_restart_hold;
    @(posedge clk) disable iff (!rst_n)
    anRestart && !anStarted && anEnabled && !softResetBusy && !(writeHit && !wData[BIT_AN_ENABLE]) |=> anRestart;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart cleared early or by zero write");

endmodule

/* File: verilog/pbmc_pkg.sv */
package pbmc_pkg;

  // clock rate of the management block
  localparam int CLK_MHZ = 250;

  // register map
  localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
  localparam int DATA_W = 16;

  // field positions within basic_mode_control
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED100 = 13;
  localparam int BIT_AN_ENABLE = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_FULL_DUPLEX = 8;

  // values after reset of the non-strapped bits
  localparam logic RST_LOOPBACK = 1'b0;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_ISOLATE = 1'b0;
  localparam logic RST_AN_RESTART = 1'b0;
  localparam logic [7:0] LOW_BYTE_READ = 8'h00;

  // soft reset length: least time, rounded up
  localparam int SOFT_RESET_NS = 1000;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] SOFT_RESET_CYCLES = CNT_W'((SOFT_RESET_NS * CLK_MHZ + 999) / 1000);

  // loopback dead time: longest time, rounded down
  localparam int LOOP_DEAD_US = 500;
  localparam int DEAD_W = 17;
  localparam int LOOP_DEAD_CYCLES = LOOP_DEAD_US * CLK_MHZ;

  // cycles from rst_n release until strap pins are through the synchroniser
  localparam logic [1:0] STRAP_WAIT_CYCLES = 2'h3;

  // management frame fields
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [4:0] OP_BITS = 5'h02;
  localparam logic [4:0] ADDR_BITS = 5'h05;
  localparam logic [4:0] TA_BITS = 5'h02;
  localparam logic [4:0] DATA_BITS = 5'h10;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_START = 3'b001,
    MS_OP = 3'b010,
    MS_PHYAD = 3'b011,
    MS_REGAD = 3'b100,
    MS_TA = 3'b101,
    MS_WDATA = 3'b110,
    MS_RDATA = 3'b111
  } pbmc_mstate_e;

  typedef struct packed {
    logic anEnable;
    logic speed100;
    logic fullDuplex;
    logic [4:0] phyAddr;
  } pbmc_strap_s;

  typedef struct packed {
    logic loopback;
    logic speed100;
    logic anEnable;
    logic powerDown;
    logic isolate;
    logic fullDuplex;
  } pbmc_ctl_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } pbmc_mii_s;

endpackage

/* File: verilog/pbmc_mii_path.sv */
`timescale 1ns/1ps
module pbmc_mii_path #(
  parameter int DEAD_CYCLES = pbmc_pkg::LOOP_DEAD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control from the register bank
  input wire logic loopback,
  input wire logic isolate,
  input wire logic powerDown,
  // mac side
  input wire pbmc_pkg::pbmc_mii_s macTx,
  output pbmc_pkg::pbmc_mii_s macRx,
  output logic macRxOe_n,
  // line side
  input wire pbmc_pkg::pbmc_mii_s lineRx,
  output pbmc_pkg::pbmc_mii_s lineTx
);
  import pbmc_pkg::*;

  typedef struct packed {
    logic loopPrev;
    logic [DEAD_W-1:0] deadCnt;
    pbmc_mii_s rxOut;
    pbmc_mii_s txOut;
  } pbmc_path_s;

  pbmc_path_s s_reg;
  pbmc_path_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.loopPrev = loopback;
    // descrambler resync window after loopback turns on
    if (loopback && !s_reg.loopPrev) begin
      s_next.deadCnt = DEAD_W'(DEAD_CYCLES - 1);
    end else if (s_reg.deadCnt != '0) begin
      s_next.deadCnt = s_reg.deadCnt - DEAD_W'(1);
    end
    if (powerDown || isolate) begin
      s_next.rxOut = '0;
    end else if (loopback) begin
      s_next.rxOut = macTx;
      // the edge cycle itself is withheld too, the counter only loads then
      if (s_reg.deadCnt != '0 || !s_reg.loopPrev) begin
        s_next.rxOut.dv = 1'b0;
      end
    end else begin
      s_next.rxOut = lineRx;
    end
    // loopback keeps transmit data off the line
    if (powerDown || isolate || loopback) begin
      s_next.txOut = '0;
    end else begin
      s_next.txOut = macTx;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign macRx = s_reg.rxOut;
  assign lineTx = s_reg.txOut;
  assign macRxOe_n = isolate;

  sequence s_dead_rx;
    !macRx.dv [*8];
  endsequence

  property p_loop_dead;
    @(posedge clk) disable iff (!rst_n)
    $rose(loopback) && !isolate && !powerDown |=> s_dead_rx;
  endproperty
  a_loop_dead: assert property (p_loop_dead) else $error("rx valid during loopback dead time");

  property p_loop_route;
    @(posedge clk) disable iff (!rst_n)
    loopback && !isolate && !powerDown && s_reg.deadCnt == '0 |=> macRx.d == $past(macTx.d) && lineTx == '0;
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback data not routed");

  property p_isolate;
    @(posedge clk) disable iff (!rst_n)
    isolate |-> macRxOe_n ##1 macRx == '0;
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolated port still drives mii");

  property p_power_down;
    @(posedge clk) disable iff (!rst_n)
    powerDown |=> lineTx == '0 && macRx == '0;
  endproperty
  a_power_down: assert property (p_power_down) else $error("powered down path active");

endmodule

/* File: verif/pbmc_mgmt_master.sv */
`timescale 1ns/1ps
module pbmc_mgmt_master (
  // clock
  input wire logic clk,
  // management wire, tri-state with pull-up
  output logic mdc,
  output logic mdioDrv,
  output logic mdioBit,
  input wire logic mdioWire
);
  import pbmc_pkg::*;
  // mdc half period in clk cycles, set by the bench for prompt or slow frames
  int half = 4;
  initial begin
    mdc = 1'b0;
    mdioDrv = 1'b0;
    mdioBit = 1'b1;
  end
  // data moves in the low phase, sampled just before the rise
  task automatic bit_cycle(input logic drv, input logic val, output logic seen);
    mdioDrv = drv;
    mdioBit = val;
    repeat (half) @(posedge clk);
    #1;
    seen = mdioWire;
    mdc = 1'b1;
    repeat (half) @(posedge clk);
    #1;
    mdc = 1'b0;
  endtask
  // reads release the wire from turnaround on; last 17 samples are ta bit plus data
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] regad,
      input logic [15:0] wdata, output logic [16:0] rdata);
    logic [33:0] hdr;
    logic s;
    hdr = {4'b1101, rd ? OP_READ : OP_WRITE, phy, regad, 2'b10, wdata};
    rdata = '0;
    for (int i = 33; i >= 0; i--) begin
      if (!rd || i >= 18)
        bit_cycle(1'b1, hdr[i], s);
      else begin
        bit_cycle(1'b0, 1'b1, s);
        rdata = {rdata[15:0], s};
      end
    end
    mdioDrv = 1'b0;
    // one edge with the wire released before a following frame drives it again
    @(posedge clk);
    #1;
  endtask
endmodule

/* File: verif/test_phy_basic_mode_control.sv */
`timescale 1ns/1ps
module test_phy_basic_mode_control;
  import pbmc_pkg::*;
  // short dead time keeps the run brief
  localparam int DEAD = 20;
  logic clk, rst_n, mdc, mdioIn, mdioOut, mdioOe_n, mDrv, mBit;
  logic anStarted, anSpeed100, anFullDuplex, anEnabled, anRestart, softResetBusy;
  logic opSpeed100, opFullDuplex, powerDown, isolate, macRxOe_n;
  pbmc_strap_s strapPins;
  pbmc_mii_s macTx, macRx, lineRx, lineTx;
  int failures = 0;
  int n_compared = 0;
  logic [15:0] busyCnt = '0;
  logic [15:0] w, v;
  logic [4:0] phy;
  logic pend = 1'b0;

  // pull-up wins when nobody drives
  assign mdioIn = !mdioOe_n ? mdioOut : (mDrv ? mBit : 1'b1);

  pbmc_top #(.LOOP_DEAD_CYCLES(DEAD)) uut (.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .strapPins(strapPins), .anStarted(anStarted),
    .anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex), .anEnabled(anEnabled), .anRestart(anRestart),
    .softResetBusy(softResetBusy), .opSpeed100(opSpeed100), .opFullDuplex(opFullDuplex),
    .powerDown(powerDown), .isolate(isolate), .macTx(macTx), .macRx(macRx), .macRxOe_n(macRxOe_n),
    .lineRx(lineRx), .lineTx(lineTx));
  pbmc_mgmt_master mgr (.clk(clk), .mdc(mdc), .mdioDrv(mDrv), .mdioBit(mBit), .mdioWire(mdioIn));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) if (softResetBusy === 1'b1) busyCnt <= busyCnt + 16'h0001;

  task automatic conclude();
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] d);
    logic [16:0] r;
    mgr.frame(1'b0, phy, 5'h00, d, r);
  endtask

  task automatic rd(input logic [4:0] p, input logic [4:0] a, output logic [15:0] d);
    logic [16:0] r;
    mgr.frame(1'b1, p, a, 16'h0000, r);
    d = r[15:0];
  endtask

  // written control bits come back, restart reads as pending, low byte and reset bit read zero
  function automatic logic [15:0] expw(input logic [15:0] d, input logic p);
    return (d & 16'h7D00) | {6'h00, p, 9'h000};
  endfunction

  function automatic logic [15:0] strapw(input pbmc_strap_s s);
    return {2'b00, s.speed100, s.anEnable, 3'b000, s.fullDuplex, 8'h00};
  endfunction

  task automatic mii_run(input logic lb, input logic pd, input logic iso);
    pbmc_mii_s eRx, eTx;
    repeat (8) begin
      macTx = pbmc_mii_s'(6'($urandom));
      lineRx = pbmc_mii_s'(6'($urandom));
      eRx = (pd | iso) ? '0 : (lb ? macTx : lineRx);
      eTx = (pd | iso | lb) ? '0 : macTx;
      cyc(1);
      chk({4'h0, macRx, lineTx}, {4'h0, eRx, eTx});
    end
  endtask

  task automatic check_mode(input logic [15:0] d);
    rd(phy, 5'h00, v);
    chk(v, expw(d, pend));
    chk({11'h000, anEnabled, anRestart, powerDown, isolate, macRxOe_n},
        {11'h000, d[12], pend, d[11], d[10], d[10]});
    chk({14'h0000, opSpeed100, opFullDuplex},
        {14'h0000, d[12] ? {anSpeed100, anFullDuplex} : {d[13], d[8]}});
    mii_run(d[14], d[11], d[10]);
  endtask

  initial begin
    void'($urandom(66840));
    rst_n = 1'b0;
    anStarted = 1'b0;
    anSpeed100 = 1'b0;
    anFullDuplex = 1'b1;
    macTx = '0;
    lineRx = '0;
    strapPins = pbmc_strap_s'(8'($urandom));
    phy = strapPins.phyAddr;
    cyc(2);
    rst_n = 1'b1;
    cyc(8);
    rd(phy, 5'h00, v);
    chk(v, strapw(strapPins));
    rd(phy, 5'h01, v);
    chk(v, 16'h0000);
    rd(phy ^ 5'h01, 5'h00, v);
    chk(v, 16'hFFFF);
    for (int i = 0; i < 10; i++) begin
      w = 16'($urandom) & 16'h7FFF;
      if (i == 0) w = 16'h1200;
      if (i == 1) w = 16'h0200;
      if (i == 2) w = 16'h2100;
      mgr.half = (i % 3 == 0) ? 9 : 4;
      wr(w);
      pend = (pend | w[9]) & w[12];
      anSpeed100 = 1'($urandom);
      anFullDuplex = 1'($urandom);
      cyc(DEAD + 10);
      check_mode(w);
      if (pend) begin
        wr(w & 16'hFDFF);
        cyc(4);
        chk({15'h0000, anRestart}, 16'h0001);
        anStarted = 1'b1;
        cyc(1);
        anStarted = 1'b0;
        cyc(1);
        pend = 1'b0;
        chk({15'h0000, anRestart}, 16'h0000);
      end
    end
    // receive valid held off after loopback turns on, then passes
    wr(16'h0000);
    macTx = pbmc_mii_s'(6'h2A);
    lineRx = '0;
    cyc(DEAD + 10);
    wr(16'h4000);
    repeat (DEAD - 7) begin
      cyc(1);
      chk({15'h0000, macRx.dv}, 16'h0000);
    end
    cyc(DEAD);
    chk({15'h0000, macRx.dv}, 16'h0001);
    // new straps only take hold through the soft reset
    strapPins = pbmc_strap_s'(8'($urandom));
    mgr.half = 4;
    wr(16'hCC00);
    chk({15'h0000, softResetBusy}, 16'h0001);
    // prompt read lands its turnaround well inside the soft reset
    rd(phy, 5'h00, v);
    chk(v, 16'hCC00);
    cyc(300);
    chk(busyCnt, SOFT_RESET_CYCLES);
    phy = strapPins.phyAddr;
    rd(phy, 5'h00, v);
    chk(v, strapw(strapPins));
    conclude();
  end

  // run needs about 13k cycles
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
